// ===== pkg/gpio_port_map.vh
// constants for the gpio port with pin multiplexer
// assumes inclusion by bare name from each design file
`ifndef GPIO_PORT_MAP_VH
`define GPIO_PORT_MAP_VH

// ------------------------------------------------
// pin and port geometry
// ------------------------------------------------
`define NPINS        42
`define PORT_W       12
`define PORT_SEL_W   2
`define PIN_IDX_W    6

// ------------------------------------------------
// pin configuration word layout
// ------------------------------------------------
`define CFG_W        5
`define CFG_FUNC_LO  0
`define CFG_FUNC_HI  1
`define CFG_PU_BIT   2
`define CFG_PD_BIT   3
`define CFG_HYS_BIT  4

// ------------------------------------------------
// function select codes
// ------------------------------------------------
`define FUNC_PORT    2'h0
`define FUNC_ALT1    2'h1
`define FUNC_ALT2    2'h2
`define FUNC_ANALOG  2'h3

// ------------------------------------------------
// reset values
// ------------------------------------------------
`define CFG_RST_PU   5'h04
`define CFG_RST_I2C  5'h00
`define I2C_PIN_A    4
`define I2C_PIN_B    5
`define DIR_RST      42'h000_0000_0000
`define OUT_RST      42'h000_0000_0000

`endif

// ===== design/gpio_pin_sense.v
// input synchroniser and edge finder for all pads
// assumes pad inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`include "gpio_port_map.vh"

module gpio_pin_sense (
  input  wire              clk_sys,   // system clock
  input  wire              rst,       // async reset, active high
  input  wire [`NPINS-1:0] pad_raw,   // raw pad levels
  output wire [`NPINS-1:0] pin_lvl,   // synchronised level
  output wire [`NPINS-1:0] pin_rise,  // one-cycle rising pulse
  output wire [`NPINS-1:0] pin_fall   // one-cycle falling pulse
);

  // ------------------------------------------------
  // synchroniser and history
  // ------------------------------------------------
  reg [`NPINS-1:0] meta_ff;  // first stage, read only by sync_ff
  reg [`NPINS-1:0] sync_ff;  // second stage
  reg [`NPINS-1:0] hist_ff;  // previous synchronised level

  // two flops then history; edge logic never sees meta_ff
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= {`NPINS{1'b0}};
      sync_ff <= {`NPINS{1'b0}};
      hist_ff <= {`NPINS{1'b0}};
    end else begin
      meta_ff <= pad_raw;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  // ------------------------------------------------
  // edge pulses, one per transition
  // ------------------------------------------------
  assign pin_lvl  = sync_ff;
  assign pin_rise = sync_ff & ~hist_ff;
  assign pin_fall = ~sync_ff & hist_ff;

endmodule

// ===== design/gpio_port_with_pin_mux.v
// gpio port with per-pin function multiplexer and pin interrupts
// assumes all control inputs are synchronous to clk_sys
// and that strobes are single-cycle pulses
`timescale 1ns/1ps
`include "gpio_port_map.vh"

// What this block does
// - per-pin direction, changeable any time
// - one write sets or clears chosen bits
// - one write loads a whole port
// - level, rising, falling or both-edge interrupts
// - detection sees pad in any function but analog
// - enabled flags merge onto one interrupt line
// - reset: inputs, pull-up from the first edge after release, except i2c pins
// - per-pin pull-up or pull-down select
// - per-pad hysteresis enable
// - config selects port or peripheral function
// - analog mode disables digital pad section
module gpio_port_with_pin_mux (
  input  wire                   clk_sys,       // system clock
  input  wire                   rst,           // async reset, active high
  // direction and output writes
  input  wire                   dir_wr,        // pulse: load direction of a port
  input  wire [`PORT_SEL_W-1:0] dir_port,      // port for dir_wr
  input  wire [`PORT_W-1:0]     dir_wdata,     // 1 = output
  input  wire                   out_wr,        // pulse: load whole port value
  input  wire [`PORT_SEL_W-1:0] out_port,      // port for out_wr
  input  wire [`PORT_W-1:0]     out_wdata,     // new port value
  input  wire                   out_set_wr,    // pulse: set masked bits
  input  wire                   out_clr_wr,    // pulse: clear masked bits
  input  wire [`NPINS-1:0]      out_mask,      // bits to set or clear
  // pin configuration writes
  input  wire                   cfg_wr,        // pulse: write one pin config
  input  wire [`PIN_IDX_W-1:0]  cfg_pin,       // pin index
  input  wire [`CFG_W-1:0]      cfg_wdata,     // hys, pd, pu, func
  // interrupt setup
  input  wire [`NPINS-1:0]      irq_level_sel, // 1 = level sensitive
  input  wire [`NPINS-1:0]      irq_both,      // 1 = both edges
  input  wire [`NPINS-1:0]      irq_polarity,  // 1 = high / rising
  input  wire [`NPINS-1:0]      irq_enable,    // per-pin enable
  input  wire                   irq_clr_wr,    // pulse: clear edge flags
  input  wire [`NPINS-1:0]      irq_clr_mask,  // flags to clear
  // peripheral side
  input  wire [`NPINS-1:0]      alt1_out,      // peripheral 1 drive value
  input  wire [`NPINS-1:0]      alt1_oe,       // peripheral 1 drive enable
  input  wire [`NPINS-1:0]      alt2_out,      // peripheral 2 drive value
  input  wire [`NPINS-1:0]      alt2_oe,       // peripheral 2 drive enable
  output wire [`NPINS-1:0]      periph_in,     // synced pad level to peripherals
  // pad side
  input  wire [`NPINS-1:0]      pad_in,        // pad input level
  output reg  [`NPINS-1:0]      pad_out,       // pad output value
  output reg  [`NPINS-1:0]      pad_oe,        // 1 = pad driven
  output reg  [`NPINS-1:0]      pad_pull_up,   // pull-up enable
  output reg  [`NPINS-1:0]      pad_pull_dn,   // pull-down enable
  output reg  [`NPINS-1:0]      pad_hyst,      // hysteresis enable
  output reg  [`NPINS-1:0]      pad_analog,    // analog mode, digital off
  // status
  output wire [`NPINS-1:0]      port_in,       // synced pin levels
  output wire [`NPINS-1:0]      dir_state,     // current direction
  output wire [`NPINS-1:0]      out_state,     // current output latch
  output wire [`NPINS-1:0]      irq_flags,     // interrupt flags
  output reg                    irq            // to vectored_interrupt_controller
);

  // ------------------------------------------------
  // port select decode
  // ------------------------------------------------
  // widens a port-wide value onto the pin vector; bits past pin 41 drop
  function [`NPINS-1:0] port_place;
    input [`PORT_SEL_W-1:0] sel;
    input [`PORT_W-1:0]     val;
    reg   [4*`PORT_W-1:0]   wide;
    begin
      wide       = {(4*`PORT_W){1'b0}};
      wide       = {{(3*`PORT_W){1'b0}}, val} << (sel * `PORT_W);
      port_place = wide[`NPINS-1:0];
    end
  endfunction

  // ------------------------------------------------
  // state
  // ------------------------------------------------
  reg  [`NPINS-1:0] dir_ff;              // 1 = output
  reg  [`NPINS-1:0] out_ff;              // output latch
  reg  [`NPINS-1:0] flag_ff;             // interrupt flags
  reg  [`CFG_W-1:0] cfg_ff [0:`NPINS-1]; // per-pin config
  wire [`NPINS-1:0] dir_sel_mask;        // pins of dir_port
  wire [`NPINS-1:0] out_sel_mask;        // pins of out_port
  wire [`NPINS-1:0] nxt_dir;
  wire [`NPINS-1:0] nxt_out;
  wire [`NPINS-1:0] nxt_flag;
  wire [`NPINS-1:0] sync_lvl;            // from the synchroniser
  wire [`NPINS-1:0] sync_rise;
  wire [`NPINS-1:0] sync_fall;
  wire [`NPINS-1:0] analog_v;            // analog mode per pin
  wire [`NPINS-1:0] nxt_pad_out;
  wire [`NPINS-1:0] nxt_pad_oe;
  wire [`NPINS-1:0] nxt_pu;
  wire [`NPINS-1:0] nxt_pd;
  wire [`NPINS-1:0] nxt_hys;
  wire [`NPINS-1:0] edge_hit;            // qualifying edge this cycle
  wire [`NPINS-1:0] level_hit;           // active level this cycle
  integer           i;

  // ------------------------------------------------
  // direction and output latches
  // ------------------------------------------------
  assign dir_sel_mask = port_place(dir_port, {`PORT_W{1'b1}});
  assign out_sel_mask = port_place(out_port, {`PORT_W{1'b1}});

  // direction of one port, the others untouched
  assign nxt_dir = dir_wr ? ((dir_ff & ~dir_sel_mask) |
                             port_place(dir_port, dir_wdata)) : dir_ff;

  // whole-port load first, then set and clear masks on top
  assign nxt_out = (((out_wr ? ((out_ff & ~out_sel_mask) |
                                port_place(out_port, out_wdata))
                             : out_ff)
                    | (out_set_wr ? out_mask : {`NPINS{1'b0}}))
                    & ~(out_clr_wr ? out_mask : {`NPINS{1'b0}}));

  // latches reset to all-input, output low
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir_ff <= `DIR_RST;
      out_ff <= `OUT_RST;
    end else begin
      dir_ff <= nxt_dir;
      out_ff <= nxt_out;
    end
  end

  // ------------------------------------------------
  // pin configuration store
  // ------------------------------------------------
  // reset gives pull-up on every pin but the two i2c pads
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `NPINS; i = i + 1) begin
        if (i == `I2C_PIN_A || i == `I2C_PIN_B) begin
          cfg_ff[i] <= `CFG_RST_I2C;
        end else begin
          cfg_ff[i] <= `CFG_RST_PU;
        end
      end
    end else begin
      // out-of-range index is ignored
      for (i = 0; i < `NPINS; i = i + 1) begin
        if (cfg_wr && cfg_pin == i[`PIN_IDX_W-1:0]) begin
          cfg_ff[i] <= cfg_wdata;
        end
      end
    end
  end

  // ------------------------------------------------
  // per-pin function multiplexer
  // ------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NPINS; g = g + 1) begin : pin_mux
      wire [1:0] func = cfg_ff[g][`CFG_FUNC_HI:`CFG_FUNC_LO];
      assign analog_v[g] = (func == `FUNC_ANALOG);
      // port, one of two peripherals, or nothing when analog
      assign nxt_pad_oe[g]  = (func == `FUNC_PORT) ? dir_ff[g]  :
                              (func == `FUNC_ALT1) ? alt1_oe[g] :
                              (func == `FUNC_ALT2) ? alt2_oe[g] :
                              1'b0;
      assign nxt_pad_out[g] = (func == `FUNC_PORT) ? out_ff[g]   :
                              (func == `FUNC_ALT1) ? alt1_out[g] :
                              (func == `FUNC_ALT2) ? alt2_out[g] :
                              1'b0;
      // pulls and hysteresis are digital, so analog turns them off
      assign nxt_pu[g]  = cfg_ff[g][`CFG_PU_BIT]  & ~analog_v[g];
      assign nxt_pd[g]  = cfg_ff[g][`CFG_PD_BIT]  & ~analog_v[g];
      assign nxt_hys[g] = cfg_ff[g][`CFG_HYS_BIT] & ~analog_v[g];
    end
  endgenerate

  // pad controls from flops, one cycle behind config
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pad_out     <= {`NPINS{1'b0}};
      pad_oe      <= {`NPINS{1'b0}};
      pad_pull_up <= {`NPINS{1'b0}};
      pad_pull_dn <= {`NPINS{1'b0}};
      pad_hyst    <= {`NPINS{1'b0}};
      pad_analog  <= {`NPINS{1'b0}};
    end else begin
      pad_out     <= nxt_pad_out;
      pad_oe      <= nxt_pad_oe;
      pad_pull_up <= nxt_pu;
      pad_pull_dn <= nxt_pd;
      pad_hyst    <= nxt_hys;
      pad_analog  <= analog_v;
    end
  end

  // ------------------------------------------------
  // input path and interrupt detection
  // ------------------------------------------------
  gpio_pin_sense u_sense (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pad_raw  (pad_in),
    .pin_lvl  (sync_lvl),
    .pin_rise (sync_rise),
    .pin_fall (sync_fall)
  );

  // analog pads read as zero and raise nothing
  assign port_in   = sync_lvl & ~analog_v;
  assign periph_in = port_in;

  // detection ignores the function select, only analog masks it
  assign edge_hit  = ~analog_v & ~irq_level_sel &
                     ((irq_both & (sync_rise | sync_fall)) |
                      (~irq_both & irq_polarity & sync_rise) |
                      (~irq_both & ~irq_polarity & sync_fall));
  assign level_hit = ~analog_v & irq_level_sel &
                     ~(sync_lvl ^ irq_polarity);

  // level flags follow the pin; edge flags stick, a new edge beats a clear
  assign nxt_flag = level_hit | edge_hit |
                    (flag_ff & ~irq_level_sel &
                     ~(irq_clr_wr ? irq_clr_mask : {`NPINS{1'b0}}));

  // flags and merged line
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_ff <= {`NPINS{1'b0}};
      irq     <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      irq     <= |(nxt_flag & irq_enable);
    end
  end

  assign irq_flags = flag_ff;
  assign dir_state = dir_ff;
  assign out_state = out_ff;

endmodule

// ===== test/gpio_port_with_pin_mux_chk.sv
// checker: output latch, analog pads, merged irq, reset pulls
// assumes it is bound onto the port block, one clock domain
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module gpio_port_with_pin_mux_chk (
  input wire                   clk_sys,     // clock
  input wire                   rst,         // reset
  input wire                   out_wr,      // whole port load
  input wire [`PORT_SEL_W-1:0] out_port,    // port picked
  input wire [`PORT_W-1:0]     out_wdata,   // port value
  input wire                   out_set_wr,  // set strobe
  input wire                   out_clr_wr,  // clear strobe
  input wire [`NPINS-1:0]      out_mask,    // set/clear bits
  input wire [`NPINS-1:0]      irq_enable,  // irq gate
  input wire [`NPINS-1:0]      pad_oe,      // pad driven
  input wire [`NPINS-1:0]      pad_pull_up, // pull-up
  input wire [`NPINS-1:0]      pad_hyst,    // hysteresis
  input wire [`NPINS-1:0]      pad_analog,  // analog mode
  input wire [`NPINS-1:0]      out_state,   // output latch
  input wire [`NPINS-1:0]      irq_flags,   // flags
  input wire                   irq          // merged line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // clear wins over set in the same cycle, so set is judged alone
  set_bits_a: assert property (out_set_wr && !out_clr_wr |=>
    (out_state & $past(out_mask)) == $past(out_mask)) else $error("set bits lost");
  clr_bits_a: assert property (out_clr_wr |=> (out_state & $past(out_mask)) == 0)
    else $error("clear bits kept");
  keep_bits_a: assert property ((out_set_wr || out_clr_wr) && !out_wr |=>
    (out_state & ~$past(out_mask)) == ($past(out_state) & ~$past(out_mask)))
    else $error("unmasked bits moved");
  port_load_a: assert property (out_wr && out_port == 2'h1 && !out_set_wr && !out_clr_wr
    |=> out_state[23:12] == $past(out_wdata)) else $error("port load wrong");
  analog_drive_a: assert property ((pad_oe & pad_analog) == 0)
    else $error("analog pad driven");
  analog_pull_a: assert property (((pad_pull_up | pad_hyst) & pad_analog) == 0)
    else $error("analog pad pulled");
  irq_merge_a: assert property (irq == |(irq_flags & $past(irq_enable)))
    else $error("irq not merged flags");
  // pad controls are flops fed from the config store, so they settle one edge after release
  reset_pull_a: assert property ($past(rst) |=> pad_pull_up == 42'h3ff_ffff_ffcf
    && pad_oe == 0 && irq_flags == 0) else $error("reset pad state wrong");
  cover property (irq && !$past(irq));
  cover property (pad_analog != 0);
  cover property (out_set_wr ##1 out_clr_wr);
endmodule

// ===== test/pad_model.sv
// board side of the pads: port drive, board drive, pulls
// assumes the bench never drives a pad the port drives
`timescale 1ns/1ps
`include "gpio_port_map.vh"
module pad_model (
  input  wire              clk_sys,     // clock
  input  wire [`NPINS-1:0] pad_out,     // port value
  input  wire [`NPINS-1:0] pad_oe,      // port drives
  input  wire [`NPINS-1:0] pad_pull_up, // pull-up on
  input  wire [`NPINS-1:0] pad_pull_dn, // pull-down on
  input  wire [`NPINS-1:0] ext_en,      // board drives
  input  wire [`NPINS-1:0] ext_val,     // board value
  output wire [`NPINS-1:0] pad_in       // pad level
);
  reg [`NPINS-1:0] float_ff = 42'h0; // undriven pads wander, never a stale level
  always @(posedge clk_sys) float_ff <= ~float_ff;
  // pull wins over wander, drivers win over pulls
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en
    & (pad_pull_up | (~pad_pull_dn & float_ff)));
endmodule

// ===== test/test_gpio_port_with_pin_mux.sv
// bench: drives writes and pads, queues notes, a monitor compares
// assumes the pad model as far side and the checker bound below
`timescale 1ns/1ps
`include "gpio_port_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("FAIL %0t output %0d mismatch", $time, n.sel); end end
bind gpio_port_with_pin_mux gpio_port_with_pin_mux_chk chk_inst (.clk_sys, .rst, .out_wr,
  .out_port, .out_wdata, .out_set_wr, .out_clr_wr, .out_mask, .irq_enable, .pad_oe,
  .pad_pull_up, .pad_hyst, .pad_analog, .out_state, .irq_flags, .irq);
module test_gpio_port_with_pin_mux;
  typedef struct {int cyc; int sel; logic [`NPINS-1:0] msk; logic [`NPINS-1:0] val;} note_t;
  localparam [`NPINS-1:0] ALL = 42'h3ff_ffff_ffff;
  reg                clk_sys, rst, dir_wr, out_wr, out_set_wr, out_clr_wr, cfg_wr, irq_clr_wr;
  reg [1:0]          dir_port, out_port;
  reg [11:0]         dir_wdata, out_wdata;
  reg [5:0]          cfg_pin;
  reg [4:0]          cfg_wdata;
  reg [`NPINS-1:0]   out_mask, irq_level_sel, irq_both, irq_polarity, irq_enable, irq_clr_mask;
  reg [`NPINS-1:0]   alt1_out, alt1_oe, alt2_out, alt2_oe, ext_en, ext_val, dexp, oexp, m;
  wire [`NPINS-1:0]  periph_in, pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_dn, pad_hyst;
  wire [`NPINS-1:0]  pad_analog, port_in, dir_state, out_state, irq_flags;
  wire               irq;
  // sel 0 pad_out .. 10 irq, 11 periph_in, one slot per watched output
  wire [`NPINS*12-1:0] obs = {periph_in, {41'h0, irq}, irq_flags, out_state, dir_state,
    port_in, pad_analog, pad_hyst, pad_pull_dn, pad_pull_up, pad_oe, pad_out};
  logic [4:0]  cw [4] = '{5'h11, 5'h08, 5'h03, 5'h06}; // alt1+hys, pull-dn, analog, alt2+pu
  logic [3:0]  md [4] = '{4'h2, 4'h1, 4'h7, 4'ha};     // level, both, polarity, start level
  logic [31:0] seed = 32'hbad3;
  note_t       q[$];
  note_t       n;
  int          cyc = 0, n_mismatch = 0, cmp_count = 0, p, i, k;
  logic [31:0] v;
  gpio_port_with_pin_mux gpio_port_with_pin_mux_inst (.clk_sys, .rst, .dir_wr, .dir_port,
    .dir_wdata, .out_wr, .out_port, .out_wdata, .out_set_wr, .out_clr_wr, .out_mask, .cfg_wr,
    .cfg_pin, .cfg_wdata, .irq_level_sel, .irq_both, .irq_polarity, .irq_enable, .irq_clr_wr,
    .irq_clr_mask, .alt1_out, .alt1_oe, .alt2_out, .alt2_oe, .periph_in, .pad_in, .pad_out,
    .pad_oe, .pad_pull_up, .pad_pull_dn, .pad_hyst, .pad_analog, .port_in, .dir_state,
    .out_state, .irq_flags, .irq);
  pad_model pad_model_inst (.clk_sys, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_dn, .ext_en,
    .ext_val, .pad_in);
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function logic [`NPINS-1:0] r42();
    logic [63:0] t;
    t = {rnd(), rnd()};
    r42 = t[`NPINS-1:0];
  endfunction
  task step(input int c); repeat (c) @(posedge clk_sys); endtask
  // d = edges after the driving edge at which the output must show it
  task note(input int d, input int s, input logic [`NPINS-1:0] mk, vl);
    q.push_back('{cyc + 1 + d, s, mk, vl & mk});
  endtask
  task done(input string s); step(6); $display("test %s done", s); endtask
  task stop_test();
    if (q.size() != 0) n_mismatch++;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin clk_sys = 1'b0; forever #20 clk_sys = ~clk_sys; end
  initial begin #400000; n_mismatch++; stop_test(); end
  // monitor: outputs are settled at the falling edge
  always @(negedge clk_sys) begin
    cyc = cyc + 1;
    while (q.size() > 0 && q[0].cyc <= cyc) begin
      n = q.pop_front();
      `CHK(obs[n.sel * `NPINS +: `NPINS] & n.msk, n.val)
    end
  end
  initial begin
    rst = 1'b1;
    {dir_wr, out_wr, out_set_wr, out_clr_wr, cfg_wr, irq_clr_wr} = '0;
    {dir_port, out_port, dir_wdata, out_wdata, cfg_pin, cfg_wdata} = '0;
    {out_mask, irq_level_sel, irq_both, irq_polarity, irq_enable, irq_clr_mask} = '0;
    {alt1_oe, alt2_oe, ext_en, ext_val, dexp, oexp} = '0;
    alt1_out = r42();
    alt2_out = r42();
    step(8);
    rst <= 1'b0;
    note(1, 2, ALL, 42'h3ff_ffff_ffcf);
    note(1, 1, ALL, 42'h0);
    note(1, 7, ALL, 42'h0);
    done("reset");
    // back-to-back direction and whole port loads, port 3 drops its top bits
    for (p = 0; p < 4; p++) begin
      step(1);
      v = rnd();
      {dir_wr, out_wr, dir_port, out_port} <= {2'b11, p[1:0], p[1:0]};
      {dir_wdata, out_wdata} <= v[23:0];
      for (i = 0; i < 12; i++)
        if (12 * p + i < `NPINS) {dexp[12*p+i], oexp[12*p+i]} = {v[12+i], v[i]};
      note(1, 7, ALL, dexp);
      note(1, 8, ALL, oexp);
      note(2, 1, ALL, dexp);
      note(2, 0, ALL, oexp);
    end
    // set, clear, then both at once where clear must win
    for (k = 0; k < 3; k++) begin
      step(1);
      m = r42();
      {dir_wr, out_wr, out_set_wr, out_clr_wr, out_mask} <= {2'b00, k != 1, k != 0, m};
      oexp = (k == 0) ? oexp | m : oexp & ~m;
      note(1, 8, ALL, oexp);
    end
    step(1);
    {out_set_wr, out_clr_wr, dir_wr, dir_port, dir_wdata} <= {3'b001, 14'h0};
    done("latch");
    for (k = 0; k < 4; k++) begin
      step(1);
      {dir_wr, cfg_wr, cfg_pin, cfg_wdata} <= {2'b01, 6'(7 + k), cw[k]};
    end
    step(1);
    {cfg_wr, alt1_oe, alt2_oe} <= {1'b0, 42'h80, 42'h400};
    step(3);
    note(0, 1, 42'h780, 42'h480);
    note(0, 0, 42'h480, (alt1_out & 42'h80) | (alt2_out & 42'h400));
    note(0, 2, 42'h780, 42'h400);
    note(0, 3, 42'h780, 42'h100);
    note(0, 4, 42'h780, 42'h080);
    note(0, 5, 42'h780, 42'h200);
    note(0, 6, 42'h200, 42'h000);
    note(0, 11, 42'h680, (alt1_out & 42'h80) | (alt2_out & 42'h400));
    // pin 7 parks high; its later fall is the falling-mode event
    {ext_en, irq_enable, alt1_out[7]} <= {42'h4, 42'h284, 1'b1};
    done("config");
    // rising, falling, both-edge and high-level detection on pin 2; analog pin 9 wanders yet never flags
    for (k = 0; k < 4; k++) begin
      step(1);
      {irq_level_sel[2], irq_both[2], irq_polarity[2], ext_val[2]} <= md[k];
      step(6);
      {irq_clr_wr, irq_clr_mask} <= {1'b1, ALL};
      step(1);
      irq_clr_wr <= 1'b0;
      step(4);
      ext_val[2] <= ~md[k][0];
      if (!md[k][3]) note(2, 9, 42'h4, 42'h0);
      note(3, 9, 42'h204, 42'h4);
      note(3, 10, 42'h1, 42'h1);
      step(6);
      irq_clr_wr <= 1'b1;
      note(1, 9, 42'h4, md[k][3] ? 42'h4 : 42'h0);
      note(1, 10, 42'h1, {41'h0, md[k][3]});
      step(1);
      {irq_clr_wr, irq_level_sel} <= {1'b0, 42'h0};
    end
    step(1);
    irq_clr_wr <= 1'b1;
    step(1);
    {irq_clr_wr, irq_enable, alt1_out[7]} <= {1'b0, 42'h0, 1'b0};
    note(3, 9, 42'h280, 42'h0);
    note(4, 9, 42'h280, 42'h80);
    note(4, 10, 42'h1, 42'h0);
    done("irq");
    stop_test();
  end
endmodule
